// [rip_pkg.sv]
// rip_pkg: shared constants and types for the reset, init and interrupt pin logic
// assumes one 100 MHz system clock; the bus clock is an enable pulse from a divider
package rip_pkg;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_MIN_DR_CYCLES = 41;
	localparam int DR_PER_SYS = 1;
	localparam int RESET_MIN_CYCLES = RESET_MIN_DR_CYCLES * DR_PER_SYS;
	localparam int BUS_DIV = 2;
	localparam int SYNC_DEASSERT_BUS = 1;
	localparam int SYNC_ASSERT_BUS = 1;
	localparam int ASYNC_DEASSERT_BUS = 2;
	localparam int ASYNC_ASSERT_BUS = 2;
	localparam int SELFTEST_CYCLES = 16;
	localparam int CHECKSUM_WORDS = 8;
	// ==========================================================
	// mode bits of the interrupt control setting
	localparam int MODE_PIN0_MSG = 0;
	localparam int MODE_PIN2_EXT = 1;
	localparam int MODE_PIN3_ACK = 2;
	localparam int MODE_ASYNC = 3;
	localparam int MODE_W = 4;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam int NUM_IRQ = 4;

	typedef enum logic [2:0] {
		RIP_RESET = 3'b000,
		RIP_SELFTEST = 3'b001,
		RIP_CHECKSUM = 3'b010,
		RIP_RUN = 3'b011,
		RIP_FAIL = 3'b100
	} rip_init_state_t;
endpackage

// [rip_if.sv]
// rip_if: pins between the device end and the system side
// open-drain pins are carried as output and enable; the testbench reads the enables directly
`timescale 1ns/100ps
interface rip_if;
	logic rst_req_n;
	logic bad_access_in;
	logic ready;
	logic last_ready;
	logic sync_ls_unacked;
	logic [3:0] irq_pin_n;
	logic irq3_or_ack_out_o;
	logic irq3_or_ack_out_oe;
	logic init_fault_out_o;
	logic init_fault_out_oe;
	logic lock_o;
	logic lock_oe;
	logic irq_acknowledge_out_cycle;
	logic data_cycle;

	modport device (
		input rst_req_n, bad_access_in, ready, last_ready, sync_ls_unacked, irq_pin_n,
		input irq_acknowledge_out_cycle, data_cycle,
		output irq3_or_ack_out_o, irq3_or_ack_out_oe, init_fault_out_o, init_fault_out_oe,
		output lock_o, lock_oe
	);
	modport system (
		output rst_req_n, bad_access_in, ready, last_ready, sync_ls_unacked, irq_pin_n,
		output irq_acknowledge_out_cycle, data_cycle,
		input irq3_or_ack_out_o, irq3_or_ack_out_oe, init_fault_out_o, init_fault_out_oe,
		input lock_o, lock_oe
	);
endinterface

// [rip_device.sv]
// rip_device: reset response, init self-test and checksum, bad access, irq pins
// assumes synchronous pins; the far end holds reset and shapes irq pulses
// Operation
// - bad access after last ready is fatal
// - bad access in reset selects init role
// - reset clears logic, reinitialize on release
// - in reset ignore pins, outputs idle
// - reset held at least 41 cycles
// - release reset just after clock edges
// - mode selects message or interrupt pin0
// - sync request: one low, one high cycle
// - async request: two low, two high
// - pin0 held high during reset
// - pin1 is a direct interrupt
// - pin2 interrupt or external request
// - pin3 interrupt or open-drain acknowledge
// - acknowledge latched through data cycles
// - lock asserted during acknowledge transactions
// - no ready means one more wait state
`timescale 1ns/100ps
module rip_device
	import rip_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pins
	rip_if.device pins,
	// user side
	input wire logic [MODE_W-1:0] irq_mode,
	input wire logic [31:0] mem_word,
	input wire logic selftest_ok,
	input wire logic ack_req,
	output logic [2:0] mem_index,
	output logic init_master,
	output logic bus_error,
	output logic [NUM_IRQ-1:0] irq_event,
	output logic msg_event,
	output logic ext_request_event,
	output logic init_done,
	output logic reset_seen
);
	// ==========================================================
	// bus clock enable divider
	logic [1:0] div_reg, div_next;
	logic bus_en;
	logic in_reset;
	assign in_reset = !rst_n || !pins.rst_req_n;
	assign bus_en = (div_reg == 2'(BUS_DIV - 1));
	always_comb begin
		div_next = bus_en ? 2'h0 : div_reg + 2'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_next;
		end
	end

	// ==========================================================
	// init sequence: self-test then checksum
	rip_init_state_t st_reg, st_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [31:0] sum_reg, sum_next;
	logic role_reg, role_next;
	logic err_reg, err_next;
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		sum_next = sum_reg;
		role_next = role_reg;
		err_next = 1'b0;
		if (in_reset) begin
			st_next = RIP_RESET;
			cnt_next = 5'h0;
			sum_next = 32'h0;
			role_next = pins.bad_access_in;
		end else begin
			// an error flags on the cycle after the final ready, or while sync_ls_unacked is high
			err_next = pins.bad_access_in && (pins.last_ready || pins.sync_ls_unacked);
			case (st_reg)
				RIP_RESET: begin
					st_next = RIP_SELFTEST;
					cnt_next = 5'h0;
				end
				RIP_SELFTEST: begin
					cnt_next = cnt_reg + 5'h1;
					if (cnt_reg == 5'(SELFTEST_CYCLES - 1)) begin
						st_next = selftest_ok ? RIP_CHECKSUM : RIP_FAIL;
						cnt_next = 5'h0;
					end
				end
				RIP_CHECKSUM: begin
					sum_next = sum_reg + mem_word;
					cnt_next = cnt_reg + 5'h1;
					if (cnt_reg == 5'(CHECKSUM_WORDS - 1)) begin
						st_next = (sum_next == 32'h0) ? RIP_RUN : RIP_FAIL;
					end
				end
				RIP_RUN: st_next = RIP_RUN;
				RIP_FAIL: st_next = RIP_FAIL;
				default: st_next = RIP_RESET;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg <= RIP_RESET;
			cnt_reg <= 5'h0;
			sum_reg <= 32'h0;
			role_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sum_reg <= sum_next;
			role_reg <= role_next;
			err_reg <= err_next;
		end
	end
	assign mem_index = cnt_reg[2:0];
	assign init_master = role_reg;
	assign bus_error = err_reg;
	assign init_done = (st_reg == RIP_RUN);
	assign reset_seen = (st_reg == RIP_RESET);
	// fault is open-drain: drive low while self-test runs or after a init_fault_out
	assign pins.init_fault_out_o = 1'b0;
	assign pins.init_fault_out_oe = (st_reg == RIP_SELFTEST) || (st_reg == RIP_FAIL);

	// ==========================================================
	// interrupt pins: sync, detect high-then-low request pattern
	logic [NUM_IRQ-1:0] s1_reg, s2_reg, s1_next, s2_next;
	logic [NUM_IRQ-1:0] hi_run_reg, hi_run_next;
	logic [1:0] cnt_arr_reg [NUM_IRQ];
	logic [1:0] cnt_arr_next [NUM_IRQ];
	logic [NUM_IRQ-1:0] fire;
	logic [MODE_W-1:0] mode_reg, mode_next;
	logic asyn;
	assign asyn = mode_reg[MODE_ASYNC];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
			logic smp;
			logic [1:0] need_hi, need_lo;
			assign smp = asyn ? s2_reg[gi] : pins.irq_pin_n[gi];
			assign need_hi = asyn ? 2'(ASYNC_DEASSERT_BUS) : 2'(SYNC_DEASSERT_BUS);
			assign need_lo = asyn ? 2'(ASYNC_ASSERT_BUS) : 2'(SYNC_ASSERT_BUS);
			always_comb begin
				s1_next[gi] = pins.irq_pin_n[gi];
				s2_next[gi] = s1_reg[gi];
				hi_run_next[gi] = hi_run_reg[gi];
				cnt_arr_next[gi] = cnt_arr_reg[gi];
				fire[gi] = 1'b0;
				// one counter times the high run, then the low run after it
				if (bus_en) begin
					cnt_arr_next[gi] = cnt_arr_reg[gi] + 2'h1;
					if (smp && !hi_run_reg[gi]) begin
						if (cnt_arr_next[gi] >= need_hi) begin
							hi_run_next[gi] = 1'b1;
							cnt_arr_next[gi] = 2'h0;
						end
					end else if (smp) begin
						// a high sample restarts the low run
						cnt_arr_next[gi] = 2'h0;
					end else if (hi_run_reg[gi]) begin
						if (cnt_arr_next[gi] >= need_lo) begin
							fire[gi] = 1'b1;
							hi_run_next[gi] = 1'b0;
							cnt_arr_next[gi] = 2'h0;
						end
					end else begin
						// low without a fresh high run: one event per low run
						cnt_arr_next[gi] = 2'h0;
					end
				end
			end
			always_ff @(posedge clk_sys) begin
				if (in_reset) begin
					s1_reg[gi] <= 1'b1;
					s2_reg[gi] <= 1'b1;
					hi_run_reg[gi] <= 1'b0;
					cnt_arr_reg[gi] <= 2'h0;
				end else begin
					s1_reg[gi] <= s1_next[gi];
					s2_reg[gi] <= s2_next[gi];
					hi_run_reg[gi] <= hi_run_next[gi];
					cnt_arr_reg[gi] <= cnt_arr_next[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// event routing and acknowledge output
	logic [NUM_IRQ-1:0] irq_next;
	logic msg_next, ext_next;
	logic ack_reg, ack_next, lock_reg, lock_next;
	logic [NUM_IRQ-1:0] irq_reg;
	logic msg_reg, ext_reg;
	always_comb begin
		mode_next = in_reset ? MODE_RESET : irq_mode;
		irq_next = fire;
		msg_next = fire[0] && mode_reg[MODE_PIN0_MSG];
		irq_next[0] = fire[0] && !mode_reg[MODE_PIN0_MSG];
		ext_next = fire[2] && mode_reg[MODE_PIN2_EXT];
		irq_next[2] = fire[2] && !mode_reg[MODE_PIN2_EXT];
		irq_next[3] = fire[3] && !mode_reg[MODE_PIN3_ACK];
		ack_next = ack_reg;
		// held through wait states so the agent sees a stable level
		if (!mode_reg[MODE_PIN3_ACK]) begin
			ack_next = 1'b0;
		end else if (!(pins.irq_acknowledge_out_cycle && pins.data_cycle)) begin
			ack_next = ack_req && pins.irq_acknowledge_out_cycle;
		end
		lock_next = pins.irq_acknowledge_out_cycle;
		if (in_reset) begin
			irq_next = '0;
			msg_next = 1'b0;
			ext_next = 1'b0;
			ack_next = 1'b0;
			lock_next = 1'b0;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_reg <= MODE_RESET;
			irq_reg <= '0;
			msg_reg <= 1'b0;
			ext_reg <= 1'b0;
			ack_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			irq_reg <= irq_next;
			msg_reg <= msg_next;
			ext_reg <= ext_next;
			ack_reg <= ack_next;
			lock_reg <= lock_next;
		end
	end
	assign irq_event = irq_reg;
	assign msg_event = msg_reg;
	assign ext_request_event = ext_reg;
	assign pins.irq3_or_ack_out_o = 1'b0;
	assign pins.irq3_or_ack_out_oe = ack_reg;
	assign pins.lock_o = 1'b0;
	assign pins.lock_oe = lock_reg;
endmodule // rip_device

// [rip_system.sv]
// rip_system: reset source, bad-access agent and interrupt sources
// assumes the device samples pins on clk_sys; bus cycle is BUS_DIV clocks
`timescale 1ns/100ps
module rip_system
	import rip_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pins
	rip_if.system pins,
	// user side
	input wire logic reset_req,
	input wire logic init_role,
	input wire logic report_error,
	input wire logic [NUM_IRQ-1:0] raise_irq,
	input wire logic asyn_mode,
	input wire logic irq_acknowledge_out_start,
	input wire logic ready_in,
	output logic reset_busy,
	output logic [NUM_IRQ-1:0] irq_busy,
	output logic fault_seen,
	output logic ack_seen
);
	// ==========================================================
	// reset pulse of at least the minimum length
	logic [6:0] rc_reg, rc_next;
	logic [1:0] div_reg, div_next;
	logic bus_en;
	logic bad_reg, bad_next;
	logic lr_reg, lr_next, ia_reg, ia_next, dc_reg, dc_next;
	assign bus_en = (div_reg == 2'(BUS_DIV - 1));
	always_comb begin
		div_next = bus_en ? 2'h0 : div_reg + 2'h1;
		rc_next = rc_reg;
		if (reset_req && rc_reg == 7'h0) begin
			rc_next = 7'(RESET_MIN_CYCLES);
		end else if (rc_reg != 7'h0 && (rc_reg != 7'h1 || bus_en)) begin
			rc_next = rc_reg - 7'h1;
		end
		lr_next = ready_in && pins.data_cycle;
		// role strap in reset; otherwise the report stands beside last_ready
		bad_next = (rc_reg != 7'h0) ? init_role : (report_error && lr_next);
		ia_next = ia_reg ? !(ready_in && dc_reg) : irq_acknowledge_out_start;
		// the first irq_acknowledge_out cycle carries the address, data cycles follow it
		dc_next = ia_reg && ia_next;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rc_reg <= 7'(RESET_MIN_CYCLES);
			div_reg <= 2'h0;
			bad_reg <= 1'b0;
			lr_reg <= 1'b0;
			ia_reg <= 1'b0;
			dc_reg <= 1'b0;
		end else begin
			rc_reg <= rc_next;
			div_reg <= div_next;
			bad_reg <= bad_next;
			lr_reg <= lr_next;
			ia_reg <= ia_next;
			dc_reg <= dc_next;
		end
	end
	assign pins.rst_req_n = (rc_reg == 7'h0);
	assign pins.bad_access_in = bad_reg;
	assign pins.ready = ready_in;
	assign pins.last_ready = lr_reg;
	assign pins.sync_ls_unacked = 1'b0;
	assign pins.irq_acknowledge_out_cycle = ia_reg;
	assign pins.data_cycle = dc_reg;
	assign reset_busy = (rc_reg != 7'h0);
	assign fault_seen = pins.init_fault_out_oe;
	assign ack_seen = pins.irq3_or_ack_out_oe;

	// ==========================================================
	// interrupt sources: high run then low run, in bus cycles
	logic [NUM_IRQ-1:0] pin_reg, pin_next;
	logic [2:0] ph_reg [NUM_IRQ];
	logic [2:0] ph_next [NUM_IRQ];
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi++) begin : g_src
			logic [2:0] span;
			assign span = asyn_mode ? 3'(ASYNC_DEASSERT_BUS + ASYNC_ASSERT_BUS) :
				3'(SYNC_DEASSERT_BUS + SYNC_ASSERT_BUS);
			always_comb begin
				ph_next[gi] = ph_reg[gi];
				pin_next[gi] = 1'b1;
				if (ph_reg[gi] == 3'h0) begin
					if (raise_irq[gi] && !reset_busy) begin
						ph_next[gi] = span;
					end
				end else if (bus_en) begin
					ph_next[gi] = ph_reg[gi] - 3'h1;
				end
				if (ph_next[gi] != 3'h0 && ph_next[gi] <= (span >> 1)) begin
					pin_next[gi] = 1'b0;
				end
				if (reset_busy) begin
					pin_next[gi] = 1'b1;
				end
			end
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					ph_reg[gi] <= 3'h0;
					pin_reg[gi] <= 1'b1;
				end else begin
					ph_reg[gi] <= ph_next[gi];
					pin_reg[gi] <= pin_next[gi];
				end
			end
			assign irq_busy[gi] = (ph_reg[gi] != 3'h0);
		end
	endgenerate
	assign pins.irq_pin_n = pin_reg;
endmodule // rip_system

// [rip_props.sv]
// rip_props: assertions on the pins between device and system ends
// assumes one clock domain; instantiated beside rip_if by the testbench
`timescale 1ns/100ps
module rip_props
	import rip_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pins
	input wire logic rst_req_n,
	input wire logic [3:0] irq_pin_n,
	input wire logic irq_acknowledge_out_cycle,
	input wire logic data_cycle,
	input wire logic irq3_or_ack_out_oe,
	input wire logic init_fault_out_oe,
	input wire logic lock_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// reset length: 0 means unarmed, a low run seen from power-up is not judged
	int low_cnt_reg;
	int low_cnt_next;
	always_comb begin
		low_cnt_next = rst_req_n ? 1 : (low_cnt_reg == 0 ? 0 : low_cnt_reg + 1);
	end
	always_ff @(posedge clk_sys) begin
		low_cnt_reg <= rst_n ? low_cnt_next : 0;
	end
	// ==========================================================
	// assertions
	chk_reset_len: assert property (
		$rose(rst_req_n) |-> (low_cnt_reg == 0 || low_cnt_reg > RESET_MIN_CYCLES))
		else $error("reset pulse too short");
	chk_reset_idle: assert property (
		!rst_req_n ##1 !rst_req_n |-> !(init_fault_out_oe || lock_oe || irq3_or_ack_out_oe))
		else $error("output driven in reset");
	chk_selftest_fault: assert property (
		$rose(rst_req_n) |-> ##[1:3] init_fault_out_oe[*8])
		else $error("fault not shown during self-test");
	chk_fault_release: assert property (
		$rose(rst_req_n) |-> ##[14:20] !init_fault_out_oe)
		else $error("fault not released after self-test");
	chk_checksum_gap: assert property (
		$fell(init_fault_out_oe) && rst_req_n |-> !init_fault_out_oe[*7])
		else $error("fault back too early");
	chk_fault_holds: assert property (
		$fell(init_fault_out_oe) |-> !rst_req_n || !$past(init_fault_out_oe, 18))
		else $error("latched fault released");
	chk_ack_only_irq_acknowledge_out: assert property (
		irq3_or_ack_out_oe |-> irq_acknowledge_out_cycle || $past(irq_acknowledge_out_cycle))
		else $error("acknowledge outside irq_acknowledge_out");
	chk_ack_stable: assert property (
		(irq_acknowledge_out_cycle && data_cycle)[*2] |-> $stable(irq3_or_ack_out_oe))
		else $error("acknowledge moved in data cycle");
	chk_lock_irq_acknowledge_out: assert property (
		irq_acknowledge_out_cycle && $past(irq_acknowledge_out_cycle) |-> lock_oe)
		else $error("lock missing in irq_acknowledge_out");
	for (genvar g = 0; g < 4; g++) begin : g_pin
		chk_irq_shape: assert property (
			$fell(irq_pin_n[g]) |-> $past(irq_pin_n[g], 2) && !irq_pin_n[g] ##1 !irq_pin_n[g])
			else $error("irq pulse too short");
	end
	cover property ($fell(init_fault_out_oe));
	cover property (lock_oe && irq3_or_ack_out_oe);
	cover property ($fell(irq_pin_n[0]));
endmodule // rip_props

// [reset_init_interrupt_pins_tb.sv]
// reset_init_interrupt_pins_tb: device and system ends joined by rip_if
// assumes 100 MHz clk_sys; inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module reset_init_interrupt_pins_tb;
	import rip_pkg::*;
	logic clk_sys, rst_n, reset_req, init_role, report_error, asyn_mode, irq_acknowledge_out_start;
	logic ready_in, selftest_ok, ack_req, init_master, bus_error, msg_event;
	logic ext_request_event, init_done, reset_seen, reset_busy, fault_seen, ack_seen;
	logic [3:0] raise_irq, irq_busy, irq_mode, irq_event;
	logic [31:0] mem_word;
	logic [2:0] mem_index;
	int n_mismatch, num_checks;
	rip_if pins();
	rip_device rip_device_i(.clk_sys, .rst_n, .pins(pins), .irq_mode, .mem_word,
		.selftest_ok, .ack_req, .mem_index, .init_master, .bus_error, .irq_event,
		.msg_event, .ext_request_event, .init_done, .reset_seen);
	rip_system rip_system_i(.clk_sys, .rst_n, .pins(pins), .reset_req, .init_role,
		.report_error, .raise_irq, .asyn_mode, .irq_acknowledge_out_start, .ready_in, .reset_busy,
		.irq_busy, .fault_seen, .ack_seen);
	rip_props rip_props_i(.clk_sys, .rst_n, .rst_req_n(pins.rst_req_n),
		.irq_pin_n(pins.irq_pin_n), .irq_acknowledge_out_cycle(pins.irq_acknowledge_out_cycle),
		.data_cycle(pins.data_cycle), .irq3_or_ack_out_oe(pins.irq3_or_ack_out_oe),
		.init_fault_out_oe(pins.init_fault_out_oe), .lock_oe(pins.lock_oe));
	// ==========================================================
	// helpers
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic probe(int k);
		case (k)
			0: return init_done;
			1: return bus_error;
			2: return pins.irq3_or_ack_out_oe;
			3: return msg_event;
			4: return ext_request_event;
			9: return !reset_busy;
			default: return irq_event[k-5];
		endcase
	endfunction
	// event outputs stand one cycle, so poll every cycle
	task automatic wait_for(int k, int lim);
		for (int c = 0; c < lim; c++) begin
			tick(1);
			if (probe(k) === 1'b1) begin
				chk(1, 1);
				return;
			end
		end
		$display("ERROR t=%0t got=%h exp=%h", $time, 0, k);
		n_mismatch++;
		end_sim();
	endtask
	// ==========================================================
	// scenarios
	task automatic do_reset(logic role, logic [31:0] w, logic ok);
		init_role = role;
		mem_word = w;
		reset_req = 1;
		tick(1);
		reset_req = 0;
		raise_irq = 4'h2; // pin 1 stays quiet in reset
		tick(1);
		raise_irq = 4'h0;
		tick(10);
		chk(irq_event, 0);
		chk(pins.init_fault_out_oe, 0);
		chk(reset_seen, 1);
		chk(mem_index, 3'h0);
		wait_for(9, 100);
		tick(40);
		chk(init_done, ok);
		chk(pins.init_fault_out_oe, !ok);
		chk(fault_seen, !ok);
		chk(init_master, role);
		chk(reset_seen, 0);
		$display("reset role %0d word %h done", role, w);
	endtask
	task automatic t_irq(logic [3:0] mode, int pin, int k);
		irq_mode = mode;
		asyn_mode = mode[3];
		tick(2);
		raise_irq[pin] = 1'b1;
		tick(1);
		raise_irq = 4'h0;
		wait_for(k, 60);
		tick(12);
		chk(pins.irq_pin_n, 4'hf);
		chk(irq_busy, 4'h0);
		$display("irq pin %0d mode %h done", pin, mode);
	endtask
	task automatic t_irq_acknowledge_out();
		irq_mode = 4'h4;
		ack_req = 1;
		ready_in = 0;
		tick(2);
		irq_acknowledge_out_start = 1;
		tick(1);
		irq_acknowledge_out_start = 0;
		wait_for(2, 30);
		chk(pins.lock_oe, 1);
		// wait states: acknowledge must hold through the stretched data cycles
		tick(3);
		chk(ack_seen, 1);
		chk(pins.lock_oe, 1);
		ready_in = 1;
		tick(3);
		chk(ack_seen, 0);
		chk(pins.lock_oe, 0);
		ack_req = 0;
		irq_mode = 4'h0;
		$display("irq_acknowledge_out done");
	endtask
	task automatic t_bad();
		ready_in = 0;
		report_error = 1;
		irq_acknowledge_out_start = 1;
		tick(1);
		irq_acknowledge_out_start = 0;
		tick(3);
		chk(bus_error, 0);
		ready_in = 1;
		wait_for(1, 40);
		report_error = 0;
		tick(6);
		$display("bad access done");
	endtask
	// ==========================================================
	// main sequence
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		n_mismatch = 0;
		num_checks = 0;
		{rst_n, reset_req, init_role, report_error, asyn_mode, irq_acknowledge_out_start, ack_req} = 7'h0;
		raise_irq = 4'h0;
		irq_mode = 4'h0;
		mem_word = 32'h0;
		ready_in = 1;
		selftest_ok = 1;
		repeat (12) @(posedge clk_sys);
		#1;
		rst_n = 1;
		tick(2);
		do_reset(0, 32'h1, 0);
		do_reset(1, 32'h20000000, 1);
		t_irq(4'h0, 0, 5);
		t_irq(4'h0, 1, 6);
		t_irq(4'h0, 2, 7);
		t_irq(4'h0, 3, 8);
		t_irq(4'h1, 0, 3);
		t_irq(4'h2, 2, 4);
		t_irq(4'h8, 1, 6);
		t_irq(4'h8, 3, 8);
		t_irq_acknowledge_out();
		t_bad();
		end_sim();
	end
endmodule // reset_init_interrupt_pins_tb
